// ==== common/cmg_pkg.sv ====
// Purpose: Constants and types for the CPU mode and memory access guard
// Assumes: Byte addresses per memory, one access request per cycle
// Notes:   Sizes in bytes, regions are contiguous from each memory's base
package cmg_pkg;

  // ==========================================================================
  // Modes and targets
  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_TEST,
    MODE_COMPAT,
    MODE_SYSTEM,
    MODE_USER
  } cmg_mode_t;

  typedef enum logic [1:0] {
    TGT_ROM,
    TGT_EEPROM,
    TGT_RAM,
    TGT_NONE
  } cmg_target_t;

  // ==========================================================================
  // Memory sizes in bytes, mode and system call counts
  localparam int unsigned ROM_BYTES      = 288 * 1024;
  localparam int unsigned ROM_APP_BYTES  = 264 * 1024;
  localparam int unsigned ROM_TEST_BYTES = 24 * 1024;
  localparam int unsigned EE_BYTES       = 52 * 1024;
  localparam int unsigned EE_MFR_BYTES   = 128;
  localparam int unsigned RAM_BYTES      = 6144;
  localparam int unsigned RAM_GP_BYTES   = 3584;
  localparam int unsigned RAM_CP_BYTES   = 2560;
  localparam int unsigned MODE_COUNT     = 5;
  localparam int unsigned SYSCALL_COUNT  = 32;

  // ==========================================================================
  // Region bases; test ROM above application ROM, manufacturer EEPROM at bottom
  localparam logic [18:0] ROM_TEST_BASE = 19'(ROM_APP_BYTES);
  localparam logic [18:0] ROM_LIMIT     = 19'(ROM_BYTES);
  localparam logic [18:0] EE_APP_BASE   = 19'(EE_MFR_BYTES);
  localparam logic [18:0] EE_LIMIT      = 19'(EE_BYTES);
  localparam logic [18:0] RAM_CP_BASE   = 19'(RAM_GP_BYTES);
  localparam logic [18:0] RAM_LIMIT     = 19'(RAM_BYTES);

  // Boot reservation of RAM, a small block at the top of general RAM
  localparam logic [18:0] RAM_BOOT_BASE  = 19'(RAM_GP_BYTES - 256);
  localparam logic [18:0] RAM_BOOT_LIMIT = 19'(RAM_GP_BYTES);

  // Reset values
  localparam cmg_mode_t MODE_RESET  = MODE_BOOT;
  localparam logic      GRANT_RESET = 1'b0;

endpackage

// ==== rtl/cmg_access_guard.sv ====
// Purpose: Holds the CPU privilege mode and checks CPU and coprocessor accesses
// Assumes: CPU and coprocessor requests are on core_clk; test-disable fuse is a pin
// Notes:   Answers are registered, one cycle after the request
//
// Operation
// (R1) Five CPU modes: boot, test, compatibility, system and user.
// (R2) Privileged state is always exactly one sub-mode, held internally only.
// (R3) System mode reaches every special function register.
// (R4) User mode reaches only CPU and user subset unless granted more.
// (R5) Only system mode may grant user more rights, effective afterwards.
// (R6) Exceptions and interrupts vector to fixed ROM and set that vector's mode.
// (R7) Thirty-two explicit system call vectors each enter system mode.
// (R8) ROM 288k, RAM 6144, EEPROM 52k, all access controlled.
// (R9) ROM split into 264k application and 24k test regions.
// (R10) 128 manufacturer EEPROM bytes blocked to system and user modes.
// (R11) RAM shared by all modes except boot's temporary reservation.
// (R12) Test mode has unrestricted memory access.
// (R13) Boot and compatibility reach test ROM and manufacturer EEPROM only.
// (R14) System and user reach application ROM, EEPROM; user further checked.
// (R15) RAM: 3584 general and 2560 coprocessor; coprocessor only its own.
// (R16) Coprocessor RAM and EEPROM accesses skip the rights check.
// (R17) Coprocessor still confined to the application partitions.
// (R18) Every reset starts in boot mode running boot ROM.
// (R19) Before test disable, start-up hands over to test mode.
// (R20) After test disable, start-up hands over to system; test unreachable.
// (R21) Refused access is blocked, raises an exception, leaves memory untouched; a refused coprocessor access only drops copGo.
// (R22) Test-disable latch is one-way and no software can clear it.
`timescale 1ns/100ps

module cmg_access_guard
  import cmg_pkg::*;
#(
  parameter int unsigned ADDR_W  = 19,
  parameter int unsigned SFR_W   = 7,
  parameter int unsigned GRANT_W = 8
) (
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 testDisableFuse,
  input  wire logic                 bootDone,
  input  wire logic                 vectorTake,
  input  wire logic                 vectorUser,
  input  wire logic                 syscallTake,
  input  wire logic [4:0]           syscallIndex,
  input  wire logic                 modeReturnUser,
  input  wire logic                 cpuReq,
  input  wire logic                 cpuWrite,
  input  wire cmg_pkg::cmg_target_t cpuTarget,
  input  wire logic [ADDR_W-1:0]    cpuAddr,
  input  wire logic                 sfrReq,
  input  wire logic [SFR_W-1:0]     sfrAddr,
  input  wire logic                 sfrUserOk,
  input  wire logic [2:0]           sfrGroup,
  input  wire logic                 grantWrite,
  input  wire logic [GRANT_W-1:0]   grantData,
  input  wire logic                 userWinWrite,
  input  wire logic [ADDR_W-1:0]    userWinBase,
  input  wire logic [ADDR_W-1:0]    userWinLimit,
  input  wire logic                 copReq,
  input  wire cmg_pkg::cmg_target_t copTarget,
  input  wire logic [ADDR_W-1:0]    copAddr,
  output cmg_pkg::cmg_mode_t        cpuMode,
  output logic                      privileged,
  output logic                      cpuGo,
  output logic                      cpuWriteGo,
  output logic                      accessFault,
  output logic                      sfrGo,
  output logic                      copGo,
  output logic [18:0]               vectorAddr,
  output logic                      vectorLoad,
  output logic                      testDisabled
);
  import cmg_pkg::*;

  initial begin
    if (ADDR_W < 19 || GRANT_W < 8 || SFR_W < 1) begin
      $error("cmg_access_guard: address or grant width too small");
    end
  end

  // ==========================================================================
  // Reset release and fuse synchroniser
  logic rstMeta;
  logic rstSync;
  logic fuseMeta;
  logic fuseB;
  logic fuseC;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Fuse comes from a pad, three stages, change counts once last two agree
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      fuseMeta <= 1'b0;
      fuseB    <= 1'b0;
      fuseC    <= 1'b0;
    end else begin
      fuseMeta <= testDisableFuse;
      fuseB    <= fuseMeta;
      fuseC    <= fuseB;
    end
  end

  // One-way latch; nothing but reset of the fuse image itself clears it
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      testDisabled <= 1'b0;
    end else if (fuseB && fuseC) begin
      testDisabled <= 1'b1; // [R22] [R20]
    end
  end

  // ==========================================================================
  // Mode state; never more than one sub-mode since it is one enum value
  cmg_mode_t next_mode;

  always_comb begin
    next_mode = cpuMode;
    if (vectorTake) begin
      next_mode = vectorUser ? MODE_USER : MODE_SYSTEM; // [R6]
    end else if (syscallTake) begin
      next_mode = MODE_SYSTEM; // [R7]
    end else if (bootDone && cpuMode == MODE_BOOT) begin
      // Hand-over decided by the latch, so test mode dies with the fuse
      next_mode = testDisabled ? MODE_SYSTEM : MODE_TEST; // [R19] [R20]
    end else if (modeReturnUser && cpuMode == MODE_SYSTEM) begin
      next_mode = MODE_USER;
    end
    if (next_mode == MODE_TEST && testDisabled) begin
      next_mode = MODE_SYSTEM; // [R20]
    end
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      cpuMode <= MODE_RESET; // [R18]
    end else begin
      cpuMode <= next_mode; // [R1] [R2]
    end
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      privileged <= 1'b1;
    end else begin
      privileged <= (next_mode == MODE_BOOT) || (next_mode == MODE_TEST) ||
                    (next_mode == MODE_COMPAT); // [R2]
    end
  end

  // ==========================================================================
  // Vector addresses at the bottom of application ROM; syscall slots follow event slots
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      vectorAddr <= '0;
      vectorLoad <= 1'b0;
    end else begin
      vectorLoad <= vectorTake || syscallTake;
      if (vectorTake) begin
        vectorAddr <= {16'h0000, vectorUser, 2'h0}; // [R6]
      end else if (syscallTake) begin
        vectorAddr <= {11'h000, 1'b1, syscallIndex, 2'h0}; // [R7]
      end
    end
  end

  // ==========================================================================
  // User grants, writable only from system mode
  logic [GRANT_W-1:0] userGrant;
  logic [ADDR_W-1:0]  winBase;
  logic [ADDR_W-1:0]  winLimit;

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      userGrant <= '0;
      winBase   <= '0;
      winLimit  <= '0;
    end else if (cpuMode == MODE_SYSTEM) begin
      if (grantWrite) begin
        userGrant <= grantData; // [R5]
      end
      if (userWinWrite) begin
        winBase  <= userWinBase; // [R14]
        winLimit <= userWinLimit;
      end
    end
  end

  // ==========================================================================
  // Region check shared by CPU and coprocessor paths
  function automatic logic inRange(input logic [ADDR_W-1:0] a,
                                   input logic [18:0] lo,
                                   input logic [18:0] hi);
    inRange = (a >= ADDR_W'(lo)) && (a < ADDR_W'(hi));
  endfunction

  function automatic logic cpuAllowed(input cmg_mode_t m, input cmg_target_t t,
                                      input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] wb,
                                      input logic [ADDR_W-1:0] wl);
    logic ok;
    ok = 1'b0;
    case (t)
      TGT_ROM: begin
        case (m)
          MODE_TEST:   ok = inRange(a, 19'h00000, ROM_LIMIT); // [R12] [R8]
          MODE_BOOT,
          MODE_COMPAT: ok = inRange(a, ROM_TEST_BASE, ROM_LIMIT); // [R13] [R9]
          default:     ok = inRange(a, 19'h00000, ROM_TEST_BASE); // [R14] [R9]
        endcase
      end
      TGT_EEPROM: begin
        case (m)
          MODE_TEST:   ok = inRange(a, 19'h00000, EE_LIMIT); // [R12]
          MODE_BOOT,
          MODE_COMPAT: ok = inRange(a, 19'h00000, EE_APP_BASE); // [R13]
          default:     ok = inRange(a, EE_APP_BASE, EE_LIMIT); // [R10] [R14]
        endcase
      end
      TGT_RAM: begin
        ok = inRange(a, 19'h00000, RAM_LIMIT); // [R11] [R15]
        if (m != MODE_BOOT && m != MODE_TEST &&
            inRange(a, RAM_BOOT_BASE, RAM_BOOT_LIMIT)) begin
          ok = ok && 1'b1;
        end
      end
      default: ok = 1'b0;
    endcase
    if (m == MODE_USER && t != TGT_NONE) begin
      ok = ok && (a >= wb) && (a < wl); // [R14]
    end
    cpuAllowed = ok;
  endfunction

  // Boot-time RAM reservation, released once boot hands over
  logic bootRamHeld;

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      bootRamHeld <= 1'b1;
    end else if (cpuMode == MODE_BOOT && bootDone) begin
      bootRamHeld <= 1'b0;
    end
  end

  logic cpuOk;
  logic cpuReserved;
  logic sfrOk;

  assign cpuReserved = bootRamHeld && cpuMode != MODE_BOOT && cpuTarget == TGT_RAM &&
                       inRange(cpuAddr, RAM_BOOT_BASE, RAM_BOOT_LIMIT); // [R11] [R13]
  assign cpuOk = cpuAllowed(cpuMode, cpuTarget, cpuAddr, winBase, winLimit) &&
                 !cpuReserved;

  // Registered answer; a refused write never reaches the array
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      cpuGo       <= 1'b0;
      cpuWriteGo  <= 1'b0;
      accessFault <= 1'b0;
    end else begin
      cpuGo       <= cpuReq && cpuOk;
      cpuWriteGo  <= cpuReq && cpuWrite && cpuOk; // [R21]
      accessFault <= (cpuReq && !cpuOk) || (sfrReq && !sfrOk); // [R21]
    end
  end

  // ==========================================================================
  // Special function register gate
  assign sfrOk = (cpuMode != MODE_USER) || sfrUserOk || userGrant[sfrGroup]; // [R3] [R4]

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      sfrGo <= 1'b0;
    end else begin
      sfrGo <= sfrReq && sfrOk; // [R3] [R4] [R5]
    end
  end

  // ==========================================================================
  // Coprocessor: no rights check, only its own partitions
  logic copOk;

  assign copOk = (copTarget == TGT_RAM    && inRange(copAddr, RAM_CP_BASE, RAM_LIMIT)) ||
                 (copTarget == TGT_EEPROM && inRange(copAddr, EE_APP_BASE, EE_LIMIT));
  // [R15] [R16] [R17]

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      copGo <= 1'b0;
    end else begin
      copGo <= copReq && copOk; // [R16] [R17]
    end
  end

  // ==========================================================================
  // Checks
  sequence s_bootHand;
    cpuMode == MODE_BOOT && bootDone && !vectorTake && !syscallTake;
  endsequence

  a_reset_boot_mode: assert property (@(posedge core_clk)
    $rose(rstSync) |-> cpuMode == MODE_BOOT) // [R18]
    else $error("mode after reset is not boot");
  a_test_gone: assert property (@(posedge core_clk) disable iff (!rstSync)
    testDisabled |=> cpuMode != MODE_TEST) // [R20]
    else $error("test mode reached after disable");
  a_latch_oneway: assert property (@(posedge core_clk) disable iff (!rstSync)
    testDisabled |=> testDisabled) // [R22]
    else $error("test disable latch cleared");
  a_boot_to_test: assert property (@(posedge core_clk) disable iff (!rstSync)
    s_bootHand and !testDisabled |=> cpuMode == MODE_TEST) // [R19]
    else $error("boot did not hand over to test");
  a_boot_to_sys: assert property (@(posedge core_clk) disable iff (!rstSync)
    s_bootHand and testDisabled |=> cpuMode == MODE_SYSTEM) // [R20]
    else $error("boot did not hand over to system");
  a_syscall_sys: assert property (@(posedge core_clk) disable iff (!rstSync)
    syscallTake && !vectorTake |=> cpuMode == MODE_SYSTEM ##0 vectorLoad) // [R7]
    else $error("system call did not enter system mode");
  a_vector_mode: assert property (@(posedge core_clk) disable iff (!rstSync)
    vectorTake |=> cpuMode == (($past(vectorUser)) ? MODE_USER : MODE_SYSTEM)) // [R6]
    else $error("vector mode wrong");
  a_mfr_ee_block: assert property (@(posedge core_clk) disable iff (!rstSync)
    cpuReq && cpuTarget == TGT_EEPROM && cpuAddr < ADDR_W'(EE_APP_BASE) &&
    (cpuMode == MODE_SYSTEM || cpuMode == MODE_USER) |=> !cpuGo && accessFault) // [R10]
    else $error("manufacturer EEPROM reached from software mode");
  a_fault_no_write: assert property (@(posedge core_clk) disable iff (!rstSync)
    accessFault && !sfrGo |-> !cpuWriteGo) // [R21]
    else $error("write passed with fault");
  a_cop_confined: assert property (@(posedge core_clk) disable iff (!rstSync)
    copReq && copTarget == TGT_RAM && copAddr < ADDR_W'(RAM_CP_BASE) |=> !copGo) // [R15]
    else $error("coprocessor reached general RAM");

endmodule // cmg_access_guard

// ==== verification/cmg_cpu_model.sv ====
// Purpose: CPU core model issuing memory, SFR and system call requests
// Assumes: Tasks are entered just after a rising edge of core_clk
// Notes:   Released qualifiers show inverted values, except sfrUserOk and sfrAddr, which keep their last values
`timescale 1ns/100ps

module cmg_cpu_model
  import cmg_pkg::*;
(
  input  wire logic            core_clk,
  output logic                 cpuReq,
  output logic                 cpuWrite,
  output cmg_pkg::cmg_target_t cpuTarget,
  output logic [18:0]          cpuAddr,
  output logic                 sfrReq,
  output logic [6:0]           sfrAddr,
  output logic                 sfrUserOk,
  output logic [2:0]           sfrGroup,
  output logic                 syscallTake,
  output logic [4:0]           syscallIndex
);
  // ==========================================================================
  // Idle at time zero
  initial begin
    {cpuReq, cpuWrite, sfrReq, sfrUserOk, syscallTake} = 5'h00;
    {cpuAddr, sfrAddr, sfrGroup, syscallIndex} = 34'h0;
    cpuTarget = TGT_NONE;
  end

  // One memory request held across the sampling edge
  task automatic mem(input cmg_target_t t, input logic [18:0] a, input logic w);
    {cpuReq, cpuWrite, cpuAddr} = {1'b1, w, a};
    cpuTarget = t;
    @(posedge core_clk);
    #1;
    cpuReq = 1'b0;
    {cpuWrite, cpuAddr} = ~{w, a};  // Released bus no longer shows the request
    cpuTarget = cmg_target_t'(~t);
  endtask

  // One SFR access, group index doubles as the address
  task automatic sfr(input logic ok, input logic [2:0] g);
    {sfrReq, sfrUserOk, sfrGroup, sfrAddr} = {1'b1, ok, g, 4'h0, g};
    @(posedge core_clk);
    #1;
    sfrReq = 1'b0;
    sfrGroup = ~g;  // Stale group must not leak into the next decision
  endtask

  // Explicit call of one system call vector
  task automatic syscall(input logic [4:0] i);
    {syscallTake, syscallIndex} = {1'b1, i};
    @(posedge core_clk);
    #1;
    syscallTake = 1'b0;
    syscallIndex = ~i;
  endtask
endmodule  // cmg_cpu_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the CPU mode and memory access guard
// Assumes: Inputs change 1 ns after the rising edge, answers one cycle later
// Notes:   Random traffic from an xorshift seeded with 69, corners by table
`timescale 1ns/100ps

module tb;
  import cmg_pkg::*;
  logic        core_clk, resetn, testDisableFuse, bootDone, vectorTake, vectorUser;
  logic        modeReturnUser, grantWrite, userWinWrite, copReq;
  logic        cpuReq, cpuWrite, sfrReq, sfrUserOk, syscallTake;
  logic        privileged, cpuGo, cpuWriteGo, accessFault, sfrGo, copGo;
  logic        vectorLoad, testDisabled;
  logic [2:0]  sfrGroup;
  logic [4:0]  syscallIndex;
  logic [6:0]  sfrAddr;
  logic [7:0]  grantData, grant;
  logic [18:0] cpuAddr, userWinBase, userWinLimit, copAddr, vecAddr, winB, winL;
  logic [31:0] seed;
  cmg_target_t cpuTarget, copTarget;
  cmg_mode_t   cpuMode, mode;
  int          failures, compares, cycles;

  cmg_cpu_model cpu (.core_clk, .cpuReq, .cpuWrite, .cpuTarget, .cpuAddr, .sfrReq,
    .sfrAddr, .sfrUserOk, .sfrGroup, .syscallTake, .syscallIndex);

  cmg_access_guard DUT (.core_clk, .resetn, .testDisableFuse, .bootDone, .vectorTake,
    .vectorUser, .syscallTake, .syscallIndex, .modeReturnUser, .cpuReq, .cpuWrite,
    .cpuTarget, .cpuAddr, .sfrReq, .sfrAddr, .sfrUserOk, .sfrGroup, .grantWrite,
    .grantData, .userWinWrite, .userWinBase, .userWinLimit, .copReq, .copTarget,
    .copAddr, .cpuMode, .privileged, .cpuGo, .cpuWriteGo, .accessFault, .sfrGo,
    .copGo, .vectorAddr(vecAddr), .vectorLoad, .testDisabled);

  // ==========================================================================
  // Clock and hang guard, ceiling well above the planned run
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  // Expected permission: range, then partition per mode, then user window
  function automatic logic expOk(cmg_target_t t, logic [18:0] a);
    logic rng, app;
    rng = (t == TGT_ROM && a < ROM_LIMIT) || (t == TGT_EEPROM && a < EE_LIMIT)
          || (t == TGT_RAM && a < RAM_LIMIT);
    app = (t == TGT_ROM) ? a < ROM_TEST_BASE : (t == TGT_EEPROM) ? a >= EE_APP_BASE : 1'b1;
    case (mode)
      MODE_TEST:   return rng;
      MODE_SYSTEM: return rng && app;
      MODE_USER:   return rng && app && a >= winB && a < winL;
      default:     return rng && (t == TGT_RAM || !app);
    endcase
  endfunction

  task automatic chkMode();
    chk(cpuMode, mode);
    chk(privileged, mode inside {MODE_BOOT, MODE_TEST, MODE_COMPAT});
  endtask

  // One CPU access; boot-mode accesses to the boot reservation are left unchecked
  task automatic memChk(input cmg_target_t t, input logic [18:0] a);
    logic [31:0] r;
    logic w, e;
    r = rnd();
    w = (t != TGT_ROM) & r[0];
    cpu.mem(t, a, w);
    e = expOk(t, a);
    if (!(mode == MODE_BOOT && t == TGT_RAM && a >= RAM_BOOT_BASE && a < RAM_BOOT_LIMIT))
      chk({cpuGo, cpuWriteGo, accessFault}, {e, e & w, ~e});
    step(1);  // Idle edge so the next request is not raised as this one drops
  endtask

  // Partition corners, then random traffic across each memory and just past its limit, or within 4 bytes of the user window in user mode
  task automatic sweep();
    cmg_target_t ct[9] = '{TGT_ROM, TGT_ROM, TGT_ROM, TGT_ROM, TGT_EEPROM, TGT_EEPROM,
                           TGT_EEPROM, TGT_RAM, TGT_RAM};
    logic [18:0] ca[9] = '{ROM_TEST_BASE - 19'h1, ROM_TEST_BASE, ROM_LIMIT - 19'h1,
                           ROM_LIMIT, EE_APP_BASE - 19'h1, EE_APP_BASE, EE_LIMIT - 19'h1,
                           RAM_LIMIT - 19'h1, RAM_LIMIT};
    logic [31:0] r, lim;
    cmg_target_t t;
    for (int i = 0; i < 9; i++) memChk(ct[i], ca[i]);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      t = cmg_target_t'(r[1:0]);
      lim = (t == TGT_ROM) ? ROM_BYTES : (t == TGT_EEPROM) ? EE_BYTES : RAM_BYTES;
      if (mode == MODE_USER) memChk(t, winB - 19'h4 + 19'(r[31:13] % (winL - winB + 8)));
      else memChk(t, 19'(r[31:13] % (lim + 8)));
    end
  endtask

  task automatic doReset(input logic fuse);
    resetn = 1'b0;
    testDisableFuse = fuse;
    {winB, winL, grant} = 46'h0;
    step(10);
    resetn = 1'b1;
    step(6);
    mode = MODE_BOOT;
    chkMode();
    chk(testDisabled, fuse);
  endtask

  task automatic end_of_test();
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'd69;
    {resetn, testDisableFuse, bootDone, vectorTake, vectorUser} = 5'h00;
    {modeReturnUser, grantWrite, userWinWrite, copReq, grantData} = 12'h000;
    {userWinBase, userWinLimit, copAddr} = 57'h0;
    copTarget = TGT_NONE;
    doReset(1'b0);
    sweep();
    pulse(bootDone);
    mode = MODE_TEST;
    chkMode();
    sweep();
    doReset(1'b1);
    pulse(bootDone);
    mode = MODE_SYSTEM;
    chkMode();
    step(1);
    pulse(bootDone);
    chkMode();
    testDisableFuse = 1'b0;
    step(5);
    chk(testDisabled, 1'b1);
    sweep();
    cpu.sfr(1'b0, 3'h5);
    chk({sfrGo, accessFault}, 2'b10);
    pulse(modeReturnUser);
    mode = MODE_USER;
    sweep();
    vectorUser = 1'b0;
    pulse(vectorTake);
    mode = MODE_SYSTEM;
    chk({cpuMode, vectorLoad, vecAddr}, {3'(MODE_SYSTEM), 1'b1, 19'h0});
    {grantData, grant} = 16'hA5A5;
    pulse(grantWrite);
    {userWinBase, userWinLimit, winB, winL} = {2{19'h100, 19'h1000}};
    pulse(userWinWrite);
    vectorUser = 1'b1;
    pulse(vectorTake);
    mode = MODE_USER;
    chk({cpuMode, vectorLoad, vecAddr}, {3'(MODE_USER), 1'b1, 19'h4});
    grantData = 8'hFF;
    pulse(grantWrite);
    sweep();
    // User SFR rights follow the grant written in system mode only
    for (int g = 0; g < 8; g++) begin
      cpu.sfr(1'b0, 3'(g));
      chk({sfrGo, accessFault}, {grant[g], ~grant[g]});
      step(1);
      cpu.sfr(1'b1, 3'(g));
      chk({sfrGo, accessFault}, 2'b10);
      step(1);
    end
    for (int i = 0; i < 32; i++) begin
      cpu.syscall(5'(i));
      chk({cpuMode, vectorLoad, vecAddr}, {3'(MODE_SYSTEM), 1'b1, 19'(128 + 4 * i)});
      pulse(modeReturnUser);
    end
    // Coprocessor ignores the user window but keeps its partitions
    for (int i = 0; i < 48; i++) begin
      seed = rnd();
      copTarget = cmg_target_t'(seed[1:0]);
      copAddr = 19'(seed[31:13] % 7000);
      copReq = 1'b1;
      step(1);
      copReq = 1'b0;
      copAddr = ~copAddr;
      chk(copGo, (copTarget == TGT_RAM && ~copAddr >= RAM_CP_BASE && ~copAddr < RAM_LIMIT)
          || (copTarget == TGT_EEPROM && ~copAddr >= EE_APP_BASE));
      step(1);
    end
    end_of_test();
  end
endmodule  // tb
